// ### verilog/ucgf_usart.sv
`timescale 1ns/10ps
// Contract
// [R1] Internal generator for async and sync master; slave uses external clock.
// [R2] Down-counter reloads divisor at zero and on low-byte write.
// [R3] One generator tick per zero, rate clk/(divisor+1).
// [R4] Transmitter divides ticks by 16, 8 or 2 by mode.
// [R5] Receiver steps 16, 8 or 2 states per bit on generator ticks.
// [R6] Bit rate is clk over 16, 8 or 2 times (divisor+1).
// [R7] Divisor is 12 bits from high and low bytes, 0 to 4095.
// [R8] Double speed uses divider 8 and 8 receive samples per bit.
// [R9] Software keeps double speed zero in synchronous mode.
// [R10] Slave clock passes sync register and edge detector, two cycles delay.
// [R11] External slave clock stays below a quarter of system clock.
// [R12] Sync mode: clock pin is input as slave, output as master.
// [R13] Sample on edge opposite to data change; polarity selects edges.
// [R14] Start, 5-9 data bits, none/even/odd parity, 1 or 2 stops.
// [R15] Start, data LSB first, parity, stops; back to back or idle.
// [R16] Start low, stop high, idle line high.
// [R17] Char size, parity mode and stop select fields set the format.
// [R18] One shared format for transmitter and receiver.
// [R19] Receiver checks only first stop bit for frame error.
// [R20] Parity is xor of data bits, inverted for odd.
// [R21] Software idles traffic before changing rate or format.
// [R22] Clock direction selects master or slave in sync mode.
// [R23] Software writes ninth bit before low data byte.
// [R24] Size codes 0-3 are 5-8 bits; parity 00 off, 10 even, 11 odd.
// [R25] Low-byte write loads high and low bytes and restarts counter.
module ucgf_usart
    import ucgf_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rdata,
    input  wire logic       rxd,
    output logic            txd,
    input  wire logic       xck_in,
    output logic            xck_out,
    output logic            xck_oe
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [3:0]  div_high;
        logic [7:0]  div_low;
        logic [11:0] cnt;
        logic [7:0]  ctrl_b;
        logic [7:0]  ctrl_c;
        logic [7:0]  rdata;
        logic        xck_s1;
        logic        xck_s2;
        logic        xck_d;
        logic        xck_o;
        logic        xck_oe;
        logic        txd;
        logic [8:0]  tx_buf;
        logic        tx_full;
        ucgf_phase_e tx_ph;
        logic [8:0]  tx_sh;
        logic [3:0]  tx_bit;
        logic [4:0]  tx_div;
        logic        tx_par;
        logic        tx_done;
        ucgf_phase_e rx_ph;
        logic [4:0]  rx_div;
        logic [3:0]  rx_bit;
        logic [8:0]  rx_sh;
        logic        rx_par;
        logic        rx_s1;
        logic        rx_s2;
        logic [8:0]  rx_data;
        logic        rx_done;
        logic        rx_ferr;
        logic        rx_perr;
    } ucgf_state_s;

    ucgf_state_s s_reg;
    ucgf_state_s s_next;

    function automatic logic [3:0] ucgf_nbits(input logic [2:0] code);
        if (code == CHAR_NINE) begin  // R24
            return 4'h9;
        end
        return {2'b01, code[1:0]} + 4'h1;
    endfunction

    // ************************************************************
    // Decoded controls
    // ************************************************************
    logic       sync_mode_select;
    logic       transfer_clock_direction;
    logic       double_speed_select;
    logic       clock_polarity_select;
    logic [2:0] char_size_field;
    logic [1:0] parity_mode_field;
    logic       stop_bits_select;
    logic       slave;
    logic       baud_tick;
    logic       tx_step;
    logic       rx_step;
    logic [4:0] ovs;
    logic [3:0] nbits;
    logic       slave_rise;
    logic       slave_fall;

    always_comb begin
        sync_mode_select         = s_reg.ctrl_c[CC_SYNC_MODE];
        transfer_clock_direction = s_reg.ctrl_b[CB_CLK_DIR];
        double_speed_select      = s_reg.ctrl_b[CB_DOUBLE];
        clock_polarity_select    = s_reg.ctrl_c[CC_POLARITY];
        char_size_field   = {s_reg.ctrl_b[CB_CHAR_SIZE2],
                             s_reg.ctrl_c[CC_CHAR_SIZE0+1 -: 2]};  // R17
        parity_mode_field = s_reg.ctrl_c[CC_PARITY0+1 -: 2];
        stop_bits_select  = s_reg.ctrl_c[CC_STOP_BITS];
        slave      = sync_mode_select & ~transfer_clock_direction;  // R22
        baud_tick  = (s_reg.cnt == 12'h000);  // R3
        slave_rise = s_reg.xck_s2 & ~s_reg.xck_d;  // R10
        slave_fall = ~s_reg.xck_s2 & s_reg.xck_d;  // R10
        nbits      = ucgf_nbits(char_size_field);  // R14
        if (sync_mode_select) begin
            ovs = OVS_SYNC;  // R4 R5
        end else if (double_speed_select) begin
            ovs = OVS_DOUBLE;  // R8
        end else begin
            ovs = OVS_NORMAL;
        end
        // Sync: tx shifts on change edge, rx samples on opposite edge
        if (slave) begin
            tx_step = clock_polarity_select ? slave_fall : slave_rise;  // R13
            rx_step = clock_polarity_select ? slave_rise : slave_fall;  // R13
        end else if (sync_mode_select) begin
            tx_step = baud_tick && (s_reg.xck_o == clock_polarity_select);
            rx_step = baud_tick && (s_reg.xck_o != clock_polarity_select);
        end else begin
            // Wrap from any count so a smaller divider never overruns
            tx_step = baud_tick && (s_reg.tx_div >= ovs - 5'h01);  // R6
            rx_step = baud_tick;  // R5
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic rx_sample;
        logic rx_bitend;
        rx_sample = 1'b0;
        rx_bitend = 1'b0;
        s_next    = s_reg;

        // Synchronisers
        s_next.xck_s1 = xck_in;
        s_next.xck_s2 = s_reg.xck_s1;
        s_next.xck_d  = s_reg.xck_s2;
        s_next.rx_s1  = rxd;
        s_next.rx_s2  = s_reg.rx_s1;

        // Baud generator
        if (baud_tick) begin
            s_next.cnt = {s_reg.div_high, s_reg.div_low};  // R2
        end else begin
            s_next.cnt = s_reg.cnt - 12'h001;
        end

        // Master clock pin
        s_next.xck_oe = sync_mode_select & transfer_clock_direction;  // R12
        if (sync_mode_select && !slave && baud_tick) begin
            s_next.xck_o = ~s_reg.xck_o;  // R1
        end else if (!sync_mode_select || slave) begin
            s_next.xck_o = clock_polarity_select;
        end

        // Transmitter
        if (baud_tick && !sync_mode_select) begin
            s_next.tx_div = (s_reg.tx_div >= ovs - 5'h01) ? 5'h00
                          : s_reg.tx_div + 5'h01;  // R4
        end
        if (tx_step) begin
            case (s_reg.tx_ph)
                UCGF_IDLE: begin
                    if (s_reg.tx_full && s_reg.ctrl_b[CB_TX_EN]) begin
                        s_next.tx_sh   = s_reg.tx_buf;
                        s_next.tx_full = 1'b0;
                        s_next.tx_par  = parity_mode_field[0];  // R20
                        s_next.txd     = 1'b0;  // R16
                        s_next.tx_ph   = UCGF_START;
                    end
                end
                UCGF_START, UCGF_DATA: begin
                    if (s_reg.tx_ph == UCGF_START) begin
                        s_next.tx_bit = 4'h0;
                    end
                    s_next.txd    = s_reg.tx_sh[0];  // R15
                    s_next.tx_par = s_reg.tx_par ^ s_reg.tx_sh[0];  // R20
                    s_next.tx_sh  = {1'b0, s_reg.tx_sh[8:1]};
                    s_next.tx_ph  = UCGF_DATA;
                    if (s_reg.tx_ph == UCGF_DATA) begin
                        s_next.tx_bit = s_reg.tx_bit + 4'h1;
                        if (s_reg.tx_bit + 4'h1 == nbits) begin
                            if (parity_mode_field[1]) begin
                                s_next.txd   = s_reg.tx_par;
                                s_next.tx_ph = UCGF_PARITY;
                            end else begin
                                s_next.txd    = 1'b1;  // R16
                                s_next.tx_bit = 4'h0;
                                s_next.tx_ph  = UCGF_STOP;
                            end
                            s_next.tx_sh = s_reg.tx_sh;
                            s_next.tx_par = s_reg.tx_par;
                        end
                    end
                end
                UCGF_PARITY: begin
                    s_next.txd    = 1'b1;
                    s_next.tx_bit = 4'h0;
                    s_next.tx_ph  = UCGF_STOP;
                end
                UCGF_STOP: begin
                    if (stop_bits_select && s_reg.tx_bit == 4'h0) begin
                        s_next.tx_bit = 4'h1;  // R14
                    end else if (s_reg.tx_full && s_reg.ctrl_b[CB_TX_EN]) begin
                        s_next.tx_sh   = s_reg.tx_buf;  // R15
                        s_next.tx_full = 1'b0;
                        s_next.tx_par  = parity_mode_field[0];
                        s_next.txd     = 1'b0;
                        s_next.tx_ph   = UCGF_START;
                    end else begin
                        s_next.tx_done = 1'b1;
                        s_next.tx_ph   = UCGF_IDLE;
                    end
                end
                default: s_next.tx_ph = UCGF_IDLE;
            endcase
        end

        // Receiver: rx_div counts oversample states within a bit
        if (rx_step && s_reg.ctrl_b[CB_RX_EN]) begin
            if (sync_mode_select) begin
                rx_sample = (s_reg.rx_ph != UCGF_IDLE) || !s_reg.rx_s2;
                rx_bitend = rx_sample;
            end else if (s_reg.rx_ph == UCGF_IDLE) begin
                s_next.rx_div = s_reg.rx_s2 ? 5'h00 : s_reg.rx_div + 5'h01;
                rx_bitend = !s_reg.rx_s2 && (s_reg.rx_div == (ovs >> 1));
                rx_sample = rx_bitend;
                if (rx_bitend) begin
                    s_next.rx_div = 5'h00;
                end
            end else begin
                s_next.rx_div = s_reg.rx_div + 5'h01;  // R5
                if (s_reg.rx_div == ovs - 5'h01) begin
                    s_next.rx_div = 5'h00;
                    rx_sample = 1'b1;  // R8
                    rx_bitend = 1'b1;
                end
            end
        end
        if (rx_sample && rx_bitend) begin
            case (s_reg.rx_ph)
                UCGF_IDLE: begin
                    s_next.rx_bit = 4'h0;
                    s_next.rx_sh  = 9'h000;
                    s_next.rx_par = parity_mode_field[0];
                    s_next.rx_ph  = UCGF_DATA;
                end
                UCGF_DATA: begin
                    s_next.rx_sh  = {s_reg.rx_s2, s_reg.rx_sh[8:1]};
                    s_next.rx_par = s_reg.rx_par ^ s_reg.rx_s2;
                    s_next.rx_bit = s_reg.rx_bit + 4'h1;
                    if (s_reg.rx_bit + 4'h1 == nbits) begin
                        s_next.rx_ph = parity_mode_field[1] ? UCGF_PARITY
                                                            : UCGF_STOP;
                    end
                end
                UCGF_PARITY: begin
                    s_next.rx_perr = s_reg.rx_par ^ s_reg.rx_s2;  // R20
                    s_next.rx_ph   = UCGF_STOP;
                end
                UCGF_STOP: begin
                    // Align LSB to bit 0 and stop at the first stop bit
                    s_next.rx_data = s_reg.rx_sh >> (4'h9 - nbits);
                    s_next.rx_ferr = ~s_reg.rx_s2;  // R19
                    if (!parity_mode_field[1]) begin
                        s_next.rx_perr = 1'b0;
                    end
                    s_next.rx_done = 1'b1;
                    s_next.rx_ph   = UCGF_IDLE;
                end
                default: s_next.rx_ph = UCGF_IDLE;
            endcase
        end

        // Register bus
        s_next.rdata = 8'h00;
        if (wr_en) begin
            case (addr)
                ADDR_DIV_LOW: begin
                    s_next.div_low = wdata;
                    s_next.cnt = {s_reg.div_high, wdata};  // R2 R25
                end
                ADDR_DIV_HIGH: s_next.div_high = wdata[3:0];  // R7
                ADDR_CTRL_B:   s_next.ctrl_b = wdata;  // R18
                ADDR_CTRL_C:   s_next.ctrl_c = wdata;  // R18
                ADDR_STATUS: begin
                    // Write one to clear; hardware set wins
                    if (wdata[ST_TX_DONE] && !s_next.tx_done) begin
                    end else if (wdata[ST_TX_DONE] && !(tx_step &&
                                 s_reg.tx_ph == UCGF_STOP)) begin
                        s_next.tx_done = 1'b0;
                    end
                end
                ADDR_TXDATA: begin
                    s_next.tx_buf  = {s_reg.ctrl_b[CB_TX_NINTH], wdata};
                    s_next.tx_full = 1'b1;
                end
                default: ;
            endcase
        end else if (rd_en) begin
            case (addr)
                ADDR_DIV_LOW:  s_next.rdata = s_reg.div_low;
                ADDR_DIV_HIGH: s_next.rdata = {4'h0, s_reg.div_high};
                ADDR_CTRL_B:   s_next.rdata = s_reg.ctrl_b;
                ADDR_CTRL_C:   s_next.rdata = s_reg.ctrl_c;
                ADDR_STATUS:   s_next.rdata = {2'b00, s_reg.rx_data[8],
                    s_reg.tx_ph != UCGF_IDLE, s_reg.rx_perr, s_reg.rx_ferr,
                    s_reg.tx_done, s_reg.rx_done};
                ADDR_RXDATA: begin
                    s_next.rdata = s_reg.rx_data[7:0];
                    if (!(rx_sample && s_reg.rx_ph == UCGF_STOP)) begin
                        s_next.rx_done = 1'b0;
                    end
                end
                default: s_next.rdata = 8'h00;
            endcase
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg        <= '0;
            s_reg.ctrl_b <= CTRL_B_RESET;
            s_reg.ctrl_c <= CTRL_C_RESET;
            s_reg.txd    <= 1'b1;
            s_reg.xck_s1 <= 1'b0;
            s_reg.tx_ph  <= UCGF_IDLE;
            s_reg.rx_ph  <= UCGF_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata   = s_reg.rdata;
    assign txd     = s_reg.txd;
    assign xck_out = s_reg.xck_o;
    assign xck_oe  = s_reg.xck_oe;

    // ************************************************************
    // Assertions
    // ************************************************************
    a_reload_value: assert property (@(posedge clk) disable iff (!rst_n)
        baud_tick && !(wr_en && addr == ADDR_DIV_LOW) |=>
        s_reg.cnt == {$past(s_reg.div_high), $past(s_reg.div_low)}) // R2
        else $error("counter did not reload divisor");
    a_low_restart: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && addr == ADDR_DIV_LOW |=>
        s_reg.cnt == {s_reg.div_high, s_reg.div_low}) // R25
        else $error("low byte write did not restart counter");
    a_idle_high: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.tx_ph == UCGF_IDLE && $past(s_reg.tx_ph) == UCGF_IDLE
        |-> txd) // R16
        else $error("idle line not high");
    a_start_low: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.tx_ph == UCGF_START |-> !txd) // R16
        else $error("start bit not low");
    a_stop_high: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.tx_ph == UCGF_STOP |-> txd) // R16
        else $error("stop bit not high");
    a_pin_dir: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 xck_oe == $past(sync_mode_select && transfer_clock_direction))
        // R12
        else $error("clock pin direction wrong");
    a_slave_edge: assert property (@(posedge clk) disable iff (!rst_n)
        slave && !clock_polarity_select && $rose(s_reg.xck_s1)
        |=> slave_rise) // R10
        else $error("slave edge not detected after two cycles");
    a_div_range: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.tx_div < OVS_NORMAL) // R4
        else $error("transmit divider out of range");
endmodule

// ### verilog/ucgf_pkg.sv
package ucgf_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [3:0] ADDR_DIV_LOW  = 4'h0;
    localparam logic [3:0] ADDR_DIV_HIGH = 4'h1;
    localparam logic [3:0] ADDR_CTRL_B   = 4'h2;
    localparam logic [3:0] ADDR_CTRL_C   = 4'h3;
    localparam logic [3:0] ADDR_STATUS   = 4'h4;
    localparam logic [3:0] ADDR_TXDATA   = 4'h5;
    localparam logic [3:0] ADDR_RXDATA   = 4'h6;

    // control_status_b fields
    localparam int CB_TX_NINTH   = 0;
    localparam int CB_CHAR_SIZE2 = 2;
    localparam int CB_DOUBLE     = 3;
    localparam int CB_TX_EN      = 4;
    localparam int CB_RX_EN      = 5;
    localparam int CB_CLK_DIR    = 6;
    // control_status_c fields
    localparam int CC_POLARITY   = 0;
    localparam int CC_CHAR_SIZE0 = 1;
    localparam int CC_STOP_BITS  = 3;
    localparam int CC_PARITY0    = 4;
    localparam int CC_SYNC_MODE  = 6;
    // status fields
    localparam int ST_RX_DONE    = 0;
    localparam int ST_TX_DONE    = 1;
    localparam int ST_FRAME_ERR  = 2;
    localparam int ST_PARITY_ERR = 3;
    localparam int ST_TX_BUSY    = 4;
    localparam int ST_RX_NINTH   = 5;

    localparam logic [7:0] CTRL_B_RESET = 8'h00;
    localparam logic [7:0] CTRL_C_RESET = 8'h06;

    // Oversampling counts per bit, size and parity codes
    localparam logic [4:0] OVS_NORMAL = 5'h10;
    localparam logic [4:0] OVS_DOUBLE = 5'h08;
    localparam logic [4:0] OVS_SYNC   = 5'h02;
    localparam logic [2:0] CHAR_NINE  = 3'h7;
    localparam logic [1:0] PAR_EVEN   = 2'h2;
    localparam logic [1:0] PAR_ODD    = 2'h3;

    typedef enum logic [2:0] {
        UCGF_IDLE, UCGF_START, UCGF_DATA, UCGF_PARITY, UCGF_STOP
    } ucgf_phase_e;
endpackage

// ### verif/ucgf_peer.sv
`timescale 1ns/10ps
// ************************************************************
// Remote serial peer
// ************************************************************
module ucgf_peer (
    input  wire logic clk,
    input  wire logic txd,
    input  wire logic xck_out,
    output logic      rxd,
    output logic      xck_in
);
    int cyc;

    initial begin
        rxd    = 1'b1;
        xck_in = 1'b0;
        cyc    = 0;
    end

    always @(posedge clk) cyc <= cyc + 1;

    // Async frame onto rxd, bit 0 first
    task automatic send(input int bc, input int nb, input logic [12:0] fr);
        for (int i = 0; i < nb; i++) begin
            rxd <= fr[i];
            repeat (bc) @(posedge clk);
        end
        rxd <= 1'b1;
    endtask

    // Async capture; start length measured, then mid-bit samples
    task automatic get(input int bc, input int nb, output logic [12:0] fr,
                       output int low);
        fr  = '1;
        low = 0;
        while (txd !== 1'b0) @(posedge clk);
        while (txd === 1'b0) begin
            low++;
            @(posedge clk);
        end
        fr[0] = 1'b0;
        for (int i = 1; i < nb; i++) begin
            repeat (bc / 2) @(posedge clk);
            fr[i] = txd;
            repeat (bc - bc / 2) @(posedge clk);
        end
    endtask

    // Sync capture; with the DUT as slave the peer makes the clock, only in frames
    task automatic sget(input bit slave, input bit pol, input int nb,
                        output logic [12:0] fr, output int per);
        int i;
        int last;
        bit lvl;
        fr   = '1;
        i    = 0;
        last = cyc;
        per  = 0;
        while (i < nb) begin
            if (slave) begin
                repeat (8) @(posedge clk);
                lvl = ~xck_in;
                xck_in <= lvl;
            end else begin
                @(xck_out);
                lvl = xck_out;
            end
            if (lvl == pol) begin
                fr[i] = txd;
                if (i > 0 || txd === 1'b0) i++;
                per  = cyc - last;
                last = cyc;
            end
        end
    endtask
endmodule

// ### verif/tb_usart_clock_gen_and_frame_format.sv
`timescale 1ns/10ps
module tb_usart_clock_gen_and_frame_format
    import ucgf_pkg::*;
;
    logic        clk;
    logic        rst_n;
    logic [3:0]  addr;
    logic [7:0]  wdata;
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  rdata;
    logic        rxd;
    logic        txd;
    logic        xck_in;
    logic        xck_out;
    logic        xck_oe;
    int          err_total;
    int          n_tests;
    int          nd_t [3]  = '{8, 5, 9};
    logic [1:0]  pm_t [3]  = '{2'h0, 2'h2, 2'h3};
    bit          two_t [3] = '{1'b0, 1'b1, 1'b0};
    bit          dbl_t [3] = '{1'b0, 1'b1, 1'b0};
    logic [8:0]  dat_t [3] = '{9'h0A5, 9'h00B, 9'h15B};
    logic [12:0] rfr_t [3] = '{13'h0278, 13'h012C, 13'h0386};
    bit          rfe_t [3] = '{1'b0, 1'b1, 1'b0};

    ucgf_usart u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rxd(rxd), .txd(txd),
        .xck_in(xck_in), .xck_out(xck_out), .xck_oe(xck_oe));
    ucgf_peer u_peer (.clk(clk), .txd(txd), .xck_out(xck_out), .rxd(rxd),
        .xck_in(xck_in));

    // ************************************************************
    // Bus and check tasks
    // ************************************************************
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic set_fmt(input int nd, input logic [1:0] pm, input bit two,
                           input bit dbl, input bit nin, input bit syn,
                           input bit mst, input bit pol);
        logic [2:0] sz;
        sz = (nd == 9) ? CHAR_NINE : 3'(nd - 5);
        wr(ADDR_CTRL_B, {1'b0, mst, 2'b11, dbl, sz[2], 1'b0, nin});
        wr(ADDR_CTRL_C, {1'b0, syn, pm, two, sz[1:0], pol});
    endtask

    // Expected frame, bit 0 first, unused bits high
    function automatic logic [12:0] mk(input int nd, input logic [1:0] pm,
                                       input bit two, input logic [8:0] d,
                                       output int nb);
        logic [12:0] f;
        logic        p;
        f    = '1;
        f[0] = 1'b0;
        p    = pm[0];
        for (int i = 0; i < nd; i++) begin
            f[i + 1] = d[i];
            p        = p ^ d[i];
        end
        nb = nd + 1;
        if (pm[1]) begin
            f[nb] = p;
            nb++;
        end
        nb = nb + (two ? 2 : 1);
        return f;
    endfunction

    // ************************************************************
    // Clock, watchdog, tests
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (50000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end

    initial begin
        logic [12:0] fr;
        logic [12:0] ef;
        logic [7:0]  d;
        int          nb;
        int          n;
        int          bc;
        rst_n = 1'b0;
        addr  = '0;
        wdata = '0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        err_total = 0;
        n_tests   = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd(ADDR_CTRL_B, d);
        chk(16'(d), 16'(CTRL_B_RESET));
        rd(ADDR_CTRL_C, d);
        chk(16'(d), 16'(CTRL_C_RESET));
        rd(4'hF, d);
        chk(16'(d), 16'h0000);
        wr(ADDR_DIV_HIGH, 8'h00);
        wr(ADDR_DIV_LOW, 8'h02);
        for (int k = 0; k < 3; k++) begin
            set_fmt(nd_t[k], pm_t[k], two_t[k], dbl_t[k], dat_t[k][8],
                    0, 0, 0);
            wr(ADDR_STATUS, 8'h02);
            ef = mk(nd_t[k], pm_t[k], two_t[k], dat_t[k], nb);
            bc = (dbl_t[k] ? 8 : 16) * 3;
            wr(ADDR_TXDATA, dat_t[k][7:0]);
            u_peer.get(bc, nb, fr, n);
            chk(16'(n), 16'(bc));
            chk(16'(fr), 16'(ef));
            repeat (2 * bc) @(posedge clk);
            rd(ADDR_STATUS, d);
            chk(16'({d[ST_TX_BUSY], d[ST_TX_DONE]}), 16'h0001);
        end
        for (int k = 0; k < 3; k++) begin
            set_fmt(8, 2'h0, rfe_t[k] ? 1'b0 : (k == 2), 0, 0, 0, 0, 0);
            u_peer.send(48, (k == 2) ? 11 : 10, rfr_t[k]);
            repeat (48) @(posedge clk);
            rd(ADDR_STATUS, d);
            chk(16'({d[ST_FRAME_ERR], d[ST_RX_DONE]}),
                16'({rfe_t[k], 1'b1}));
            rd(ADDR_RXDATA, d);
            chk(16'(d), 16'(rfr_t[k][8:1]));
        end
        repeat (600) @(posedge clk);
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_DIV_LOW, (k == 1) ? 8'h00 : 8'h02);
            set_fmt(8, 2'h0, 0, 0, 0, 1, k < 2, k[0]);
            repeat (4) @(posedge clk);
            chk(16'(xck_oe), 16'(k < 2));
            wr(ADDR_STATUS, 8'h02);
            ef = mk(8, 2'h0, 1'b0, 9'(8'h5A ^ 8'(k)), nb);
            wr(ADDR_TXDATA, 8'h5A ^ 8'(k));
            u_peer.sget(k >= 2, k[0], nb, fr, n);
            chk(16'(fr), 16'(ef));
            if (k < 2) chk(16'(n), (k == 1) ? 16'h0002 : 16'h0006);
            repeat (40) @(posedge clk);
        end
        tally_and_finish();
    end
endmodule
